/* verilog/fsk_shaping_pkg.sv */
// Shared constants, field layouts and carrier types for the FSK/GFSK shaping block.
// Assumes a 32-bit APB register bus and a single reference clock domain.
package fsk_shaping_pkg;

   // Printed register indexes; the APB byte address is four times the index
   localparam logic [7:0] IDX_DEV_CFG = 8'h1c;
   localparam logic [7:0] IDX_DIV_LOW = 8'h1d;
   localparam logic [7:0] IDX_SHP_CFG = 8'h1e;
   localparam logic [7:0] IDX_STATUS = 8'h1f;
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_DEV_CFG = {2'b00, IDX_DEV_CFG, 2'b00};
   localparam logic [11:0] ADDR_DIV_LOW = {2'b00, IDX_DIV_LOW, 2'b00};
   localparam logic [11:0] ADDR_SHP_CFG = {2'b00, IDX_SHP_CFG, 2'b00};
   localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};

   // Reset values of the byte registers
   localparam logic [7:0] DEV_CFG_RST = 8'hdf;
   localparam logic [7:0] DIV_LOW_RST = 8'h08;
   localparam logic [7:0] SHP_CFG_RST = 8'h78;

   // Field positions
   localparam int SCALE_LSB = 5;
   localparam int SCALE_W = 3;
   localparam int MAG_W = 5;
   localparam int BYPASS_BIT = 3;
   localparam int DIV_HI_W = 3;
   localparam int DIV_W = 11;
   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_RUN_BIT = 1;
   localparam int ST_RSVD_BIT = 2;
   localparam int ST_PHASE_LSB = 4;

   // Deviation arithmetic: word is in units of 1/64 of the printed factor
   localparam logic [2:0] SCALE_RSVD = 3'b101;
   localparam logic [2:0] SCALE_X2 = 3'b111;
   localparam logic [7:0] DEV_GAIN = 8'hbe;
   localparam logic [19:0] DEV_ROUND = 20'h00020;
   localparam int DEV_W = 20;

   // Shaping filter geometry
   localparam int TAPS = 16;
   localparam int SHAPE_W = 9;
   localparam int SHAPE_SHIFT = 7;
   localparam int FOFS_W = 22;
   localparam logic signed [8:0] SHAPE_FULL = 9'sh080;

   // Settings as seen by the datapath
   typedef struct packed {
      logic [2:0] scale;
      logic [4:0] mag;
      logic bypass;
      logic [10:0] div;
   } shaping_cfg_t;

   // Modulator sequencing, Gray coded
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01
   } mod_state_t;

endpackage : fsk_shaping_pkg

/* verilog/shaping_step_divider.sv */
// Programmable divider that yields the Gaussian filter step strobe.
// Assumes div and run come from flip-flops on the same clock.
module shaping_step_divider
   import fsk_shaping_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   input wire logic [DIV_W-1:0] div,
   // Strobe
   output logic step
);

   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] cnt_nxt;
   logic step_r;
   logic step_nxt;

   // Count div+1 reference cycles per step; restart while stopped
   always_comb begin
      cnt_nxt = cnt_r;
      step_nxt = 1'b0;
      if (!run) begin
         cnt_nxt = '0;
      end else if (cnt_r >= div) begin // Also catches a divider lowered mid-count
         cnt_nxt = '0;
         step_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + 11'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         step_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         step_r <= step_nxt;
      end
   end

   assign step = step_r;

endmodule : shaping_step_divider

/* verilog/fsk_gfsk_deviation_shaping_cfg.sv */
// Deviation and Gaussian shaping configuration with its shaping datapath.
// Assumes an APB master on pclk, a transmit chip stream arriving on a pin
// and a modulation type select from logic on the same clock.
//
// Register access over APB was decided locally.
module fsk_gfsk_deviation_shaping_cfg
   import fsk_shaping_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Modulator control
   input wire logic tx_enable,
   input wire logic ask_mode,
   input wire logic tx_chip_pin,
   // Modulator outputs
   output logic signed [FOFS_W-1:0] freq_offset,
   output logic [DEV_W-1:0] deviation_word,
   output logic shaping_active,
   output logic filter_step
);

   // Deviation word in 1/64 units: 190 * mag * 2^scale + 32
   function automatic logic [DEV_W-1:0] dev_calc(input logic [2:0] scale,
                                                 input logic [4:0] mag);
      logic [12:0] base;
      base = 13'(mag * DEV_GAIN);
      dev_calc = ({7'h00, base} << scale) + DEV_ROUND;
   endfunction : dev_calc

   // Symmetric tap weights approximating a Gaussian, summing to 128
   function automatic logic [4:0] tap_weight(input int idx);
      int k;
      k = (idx < TAPS / 2) ? idx : TAPS - 1 - idx;
      case (k)
         0: tap_weight = 5'h01;
         1: tap_weight = 5'h02;
         2: tap_weight = 5'h03;
         3: tap_weight = 5'h05;
         4: tap_weight = 5'h08;
         5: tap_weight = 5'h0b;
         6: tap_weight = 5'h0e;
         default: tap_weight = 5'h14;
      endcase
   endfunction : tap_weight

   // Register file state
   logic [7:0] dev_cfg_r;
   logic [7:0] dev_cfg_nxt;
   logic [7:0] div_low_r;
   logic [7:0] div_low_nxt;
   logic [7:0] shp_cfg_r;
   logic [7:0] shp_cfg_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   shaping_cfg_t cfg;

   // Pin synchroniser and modulator state
   logic [2:0] chip_sync_r;
   logic [2:0] chip_sync_nxt;
   logic chip_r;
   logic chip_nxt;
   mod_state_t state_r;
   mod_state_t state_nxt;
   logic [TAPS-1:0] hist_r;
   logic [TAPS-1:0] hist_nxt;
   logic [3:0] phase_r;
   logic [3:0] phase_nxt;
   logic signed [FOFS_W-1:0] fofs_r;
   logic signed [FOFS_W-1:0] fofs_nxt;
   logic [DEV_W-1:0] devw_r;
   logic [DEV_W-1:0] devw_nxt;
   logic active_r;
   logic active_nxt;

   // Datapath intermediates
   logic step;
   logic shaping_on;
   logic signed [SHAPE_W-1:0] shape;
   logic signed [SHAPE_W-1:0] raw_level;
   logic signed [SHAPE_W-1:0] level;
   logic signed [DEV_W+SHAPE_W:0] product;

   // APB decode
   logic wr_en;
   logic rd_setup;
   logic hit;

   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign hit = (paddr == ADDR_DEV_CFG) || (paddr == ADDR_DIV_LOW) ||
                (paddr == ADDR_SHP_CFG) || (paddr == ADDR_STATUS);
   // Zero wait states keep the bus simple; every access ends in one cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_r;

   // Register writes; an unmapped write is dropped and flagged by pslverr
   always_comb begin
      dev_cfg_nxt = dev_cfg_r;
      div_low_nxt = div_low_r;
      shp_cfg_nxt = shp_cfg_r;
      if (wr_en) begin
         case (paddr)
            ADDR_DEV_CFG: dev_cfg_nxt = pwdata[7:0];
            ADDR_DIV_LOW: div_low_nxt = pwdata[7:0];
            ADDR_SHP_CFG: shp_cfg_nxt = pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Read data captured in the setup phase so it is stable in the access phase.
   // Configuration bytes are write-only and read as zero.
   always_comb begin
      prdata_nxt = prdata_r;
      if (rd_setup) begin
         prdata_nxt = '0;
         if (paddr == ADDR_STATUS) begin
            prdata_nxt[ST_ACTIVE_BIT] = active_r;
            prdata_nxt[ST_RUN_BIT] = (state_r == ST_RUN);
            prdata_nxt[ST_RSVD_BIT] = (cfg.scale == SCALE_RSVD);
            prdata_nxt[ST_PHASE_LSB +: 4] = phase_r;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_cfg_r <= DEV_CFG_RST;
         div_low_r <= DIV_LOW_RST;
         shp_cfg_r <= SHP_CFG_RST;
         prdata_r <= '0;
      end else begin
         dev_cfg_r <= dev_cfg_nxt;
         div_low_r <= div_low_nxt;
         shp_cfg_r <= shp_cfg_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // Field extraction into the settings carrier
   always_comb begin
      cfg.scale = dev_cfg_r[SCALE_LSB +: SCALE_W];
      cfg.mag = dev_cfg_r[MAG_W-1:0];
      cfg.bypass = shp_cfg_r[BYPASS_BIT];
      cfg.div = {shp_cfg_r[DIV_HI_W-1:0], div_low_r};
   end

   // Filter runs only for FSK with bypass clear; ASK forces it off
   assign shaping_on = !ask_mode && !cfg.bypass;

   // Filter step strobe from the 11-bit divider
   shaping_step_divider u_step_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(state_r == ST_RUN && shaping_on),
      .div(cfg.div),
      .step(step)
   );

   // Three-stage pin synchroniser; a change is taken when stages two and three agree
   always_comb begin
      chip_sync_nxt = {chip_sync_r[1:0], tx_chip_pin};
      chip_nxt = chip_r;
      if (chip_sync_r[1] == chip_sync_r[2]) begin
         chip_nxt = chip_sync_r[2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chip_sync_r <= '0;
         chip_r <= 1'b0;
      end else begin
         chip_sync_r <= chip_sync_nxt;
         chip_r <= chip_nxt;
      end
   end

   // Sequencing and chip history; idle preloads the history to avoid a start transient
   always_comb begin
      state_nxt = state_r;
      hist_nxt = hist_r;
      phase_nxt = phase_r;
      case (state_r)
         ST_IDLE: begin
            hist_nxt = {TAPS{chip_r}};
            phase_nxt = '0;
            if (tx_enable) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!tx_enable) begin
               state_nxt = ST_IDLE;
            end else if (!shaping_on) begin
               hist_nxt = {TAPS{chip_r}}; // Filter held off, kept in step with data
            end else if (step) begin
               hist_nxt = {hist_r[TAPS-2:0], chip_r};
               phase_nxt = phase_r + 4'h1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Gaussian FIR over the chip history; each chip contributes plus or minus its weight
   always_comb begin
      shape = '0;
      for (int i = 0; i < TAPS; i++) begin
         if (hist_r[i]) begin
            shape = shape + SHAPE_W'(tap_weight(i));
         end else begin
            shape = shape - SHAPE_W'(tap_weight(i));
         end
      end
   end

   // Plain FSK jumps straight between the two full-scale levels
   assign raw_level = chip_r ? SHAPE_FULL : -SHAPE_FULL;
   assign level = shaping_on ? shape : raw_level;
   // Magnitude and scale multiply the filter output
   assign product = $signed({1'b0, devw_r}) * level;

   // Output stage; offset is zero when not transmitting
   always_comb begin
      devw_nxt = dev_calc(cfg.scale, cfg.mag);
      active_nxt = (state_r == ST_RUN) && shaping_on;
      fofs_nxt = '0;
      if (state_r == ST_RUN) begin
         fofs_nxt = product[FOFS_W+SHAPE_SHIFT-1:SHAPE_SHIFT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         hist_r <= '0;
         phase_r <= '0;
         fofs_r <= '0;
         devw_r <= '0;
         active_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         hist_r <= hist_nxt;
         phase_r <= phase_nxt;
         fofs_r <= fofs_nxt;
         devw_r <= devw_nxt;
         active_r <= active_nxt;
      end
   end

   assign freq_offset = fofs_r;
   assign deviation_word = devw_r;
   assign shaping_active = active_r;
   assign filter_step = step;

endmodule : fsk_gfsk_deviation_shaping_cfg

/* testbench/shaping_checker.sv */
// Port-level checks for the deviation and shaping block.
// Assumes host settings reach the block only through APB writes.
module shaping_checker
   import fsk_shaping_pkg::*;
(
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Modulator
   input wire logic tx_enable,
   input wire logic ask_mode,
   input wire logic signed [FOFS_W-1:0] freq_offset,
   input wire logic [DEV_W-1:0] deviation_word,
   input wire logic shaping_active,
   input wire logic filter_step
);
   logic [7:0] dev_r, dev_nxt;
   logic [10:0] div_r, div_nxt;
   logic byp_r, byp_nxt, arm_r, arm_nxt;
   logic [11:0] cnt_r, cnt_nxt;
   logic [1:0] age_r, age_nxt;
   logic wr, mapped;
   assign wr = psel && penable && pwrite;
   assign mapped = paddr inside {ADDR_DEV_CFG, ADDR_DIV_LOW, ADDR_SHP_CFG, ADDR_STATUS};
   // Shadow of the settings; the period check disarms on any write, as it may move the divider
   always_comb begin
      dev_nxt = (wr && paddr == ADDR_DEV_CFG) ? pwdata[7:0] : dev_r;
      div_nxt = div_r;
      byp_nxt = byp_r;
      if (wr && paddr == ADDR_DIV_LOW) div_nxt[7:0] = pwdata[7:0];
      if (wr && paddr == ADDR_SHP_CFG) div_nxt[10:8] = pwdata[2:0];
      if (wr && paddr == ADDR_SHP_CFG) byp_nxt = pwdata[BYPASS_BIT];
      age_nxt = (wr && paddr == ADDR_DEV_CFG) ? 2'h0 : (age_r == 2'h3 ? age_r : age_r + 2'h1);
      cnt_nxt = filter_step ? 12'h001 : cnt_r + 12'h001;
      arm_nxt = filter_step ? 1'b1 : ((wr || !shaping_active) ? 1'b0 : arm_r);
   end
   // Registered shadow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_r <= DEV_CFG_RST;
         div_r <= {SHP_CFG_RST[2:0], DIV_LOW_RST};
         byp_r <= SHP_CFG_RST[BYPASS_BIT];
         age_r <= 2'h0;
         cnt_r <= 12'h000;
         arm_r <= 1'b0;
      end else begin
         dev_r <= dev_nxt;
         div_r <= div_nxt;
         byp_r <= byp_nxt;
         age_r <= age_nxt;
         cnt_r <= cnt_nxt;
         arm_r <= arm_nxt;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_tx_shaped;
      (tx_enable && !ask_mode && !byp_r) [*3];
   endsequence
   chk_dev_word: assert property (
      age_r == 2'h3 && dev_r[7:5] != SCALE_RSVD |->
      deviation_word == ((20'h000be * 20'(dev_r[4:0])) << dev_r[7:5]) + 20'h00020)
      else $error("deviation word off its setting");
   chk_step_period: assert property (
      filter_step && arm_r |-> cnt_r == {1'b0, div_r} + 12'h001)
      else $error("filter step period wrong");
   chk_shaping_on: assert property (s_tx_shaped |-> shaping_active)
      else $error("shaping not active");
   chk_bypass_off: assert property (byp_r && $past(byp_r) |-> !shaping_active)
      else $error("shaping active in bypass");
   chk_ask_off: assert property (ask_mode [*2] |-> !shaping_active)
      else $error("shaping active in ask mode");
   chk_no_idle_step: assert property (!shaping_active [*3] |-> !filter_step)
      else $error("step while shaping off");
   chk_idle_zero: assert property (!tx_enable [*4] |-> freq_offset == '0)
      else $error("offset nonzero while idle");
   chk_bus_resp: assert property (psel && penable |-> pready && pslverr == !mapped)
      else $error("bad bus response");
endmodule : shaping_checker

bind fsk_gfsk_deviation_shaping_cfg shaping_checker u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .tx_enable, .ask_mode, .freq_offset,
   .deviation_word, .shaping_active, .filter_step);

/* testbench/tb.sv */
// Self-checking bench for the deviation and shaping block.
// Assumes the package, the design and the bound checker are compiled first.
module tb
   import fsk_shaping_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic tx_enable, ask_mode, tx_chip_pin;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [FOFS_W-1:0] freq_offset;
   logic [DEV_W-1:0] deviation_word;
   logic shaping_active, filter_step;
   logic signed [FOFS_W-1:0] fo;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n;

   fsk_gfsk_deviation_shaping_cfg DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tx_enable, .ask_mode, .tx_chip_pin,
      .freq_offset, .deviation_word, .shaping_active, .filter_step);

   // Clock, and a slow chip stream driven on the rising edge like every other input
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always begin
      repeat (40) @(posedge pclk);
      tx_chip_pin <= ~tx_chip_pin;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; an idle edge follows so the strobe is never driven twice at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Cycles between two filter steps, sampled on the falling edge where outputs are settled
   task automatic measure(output int cnt);
      int t;
      t = 0;
      cnt = 0;
      do begin
         @(negedge pclk);
         t++;
      end while (filter_step !== 1'b1 && t < 3000);
      do begin
         @(negedge pclk);
         cnt++;
      end while (filter_step !== 1'b1 && cnt < 3000);
      @(posedge pclk);
   endtask : measure

   function automatic logic [31:0] dev_exp(input logic [7:0] v);
      return ((32'h000000be * 32'(v[4:0])) << v[7:5]) + 32'h00000020;
   endfunction : dev_exp

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   // Watchdog: the whole run needs about 1200 cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         $display("ERROR %0t run timed out", $time);
         print_verdict();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      tx_enable = 1'b0;
      ask_mode = 1'b0;
      tx_chip_pin = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(32'(deviation_word), dev_exp(DEV_CFG_RST));
      apb(1'b0, ADDR_DEV_CFG, 32'h0, rd);
      chk(rd, 32'h0);
      apb(1'b0, 12'h100, 32'h0, rd);
      chk(rd, 32'h0);
      $display("test reset_map done");
      // Every defined scale code with one magnitude
      for (int i = 0; i < 8; i++) begin
         if (i != 5) begin
            apb(1'b1, ADDR_DEV_CFG, {24'h0, i[2:0], 5'h13}, rd);
            repeat (3) @(posedge pclk);
            chk(32'(deviation_word), dev_exp({i[2:0], 5'h13}));
         end
      end
      $display("test scale_codes done");
      // Step period, low byte only and then with high bits
      tx_enable <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, ADDR_DIV_LOW, i ? 32'h03 : 32'h0f, rd);
         apb(1'b1, ADDR_SHP_CFG, i ? 32'h02 : 32'h00, rd);
         measure(n);
         chk(32'(n), i ? 32'h204 : 32'h10);
      end
      apb(1'b0, ADDR_STATUS, 32'h0, rd);
      chk(rd & 32'h7, 32'h3);
      $display("test divider done");
      // Shaping off in ASK, back on, then off through bypass
      ask_mode <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(32'(shaping_active), 32'h0);
      ask_mode <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'(shaping_active), 32'h1);
      apb(1'b1, ADDR_SHP_CFG, 32'h0a, rd);
      repeat (4) @(posedge pclk);
      chk(32'(shaping_active), 32'h0);
      // Bypassed output jumps to the full deviation, either sign
      fo = freq_offset;
      chk(32'(fo < 0 ? -fo : fo), dev_exp(8'hf3));
      tx_enable <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(32'(freq_offset), 32'h0);
      $display("test shaping_modes done");
      print_verdict();
   end
endmodule : tb
